// file: design/pic_pkg.sv
// package for the primary interrupt control block
// Function
// [R1] top bit of control register 0 reads zero, no storage
// [R2] software keeps bits 6 and 3 of register 0 unchanged
// [R3] bit 0 of register 0 is the master interrupt enable
// [R4] register 0 bits 5 and 4 are pin 1 and pin 0 pending flags
// [R5] register 0 bits 2 and 1 enable pin 1 and pin 0
// [R6] register 1 bit 7 converter flag, bit 3 converter enable
// [R7] register 1 bit 4 comparator flag, bit 0 comparator enable
// [R8] register 1 bits 6 and 5 are group 1 and group 0 flags
// [R9] register 1 bits 2 and 1 enable group 1 and group 0
// [R10] register 2 bits 6,5 tick flags, bits 2,1 their enables
// [R11] register 2 bits 7,4 group 3,2 flags, bits 3,0 enables
// [R12] register 3 bits 7,6 group 5,4 flags, bits 3,2 enables
// [R13] register 3 bits 5,4 pin 3,2 flags, bits 1,0 enables
// [R14] per pin two-bit edge select: off, rising, falling, both
// [R15] interrupt only when flag, its enable and master enable are all set; irqOut follows status and mask without these enables
// [R16] registers 1 to 3 reset to zero and are read/write
package pic_pkg;
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] OFF_CTRL0   = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_CTRL1   = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_CTRL2   = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_CTRL3   = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_EDGESEL = 3'h4;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 3'h5;
	localparam logic [ADDR_W-1:0] OFF_MASK    = 3'h6;
	localparam logic [ADDR_W-1:0] OFF_VECTOR  = 3'h7;
	localparam logic [7:0] CTRL0_RST   = 8'h00;
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam logic [7:0] CTRL0_IMPL  = 8'h7f;
	localparam logic [7:0] CTRL0_FLAGS = 8'h30;
	localparam logic [7:0] CTRLN_FLAGS = 8'hf0;
	localparam int BIT_MASTER = 0;
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam int NUM_PINS = 4;
	localparam int NUM_SRC = 14;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} pic_bus_t;

	// internal request sources, one cycle pulses
	typedef struct packed {
		logic       converter;
		logic       cmp1;
		logic [5:0] group;
		logic [1:0] tick;
	} pic_src_t;
endpackage

// file: design/pic_edge_detect.sv
// synchroniser and edge detector for one external pin
`timescale 1ns/1ps
`default_nettype none
module pic_edge_detect (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// pin and mode
	input  wire logic       pinIn,
	input  wire logic [1:0] edgeSel,
	// detected edge
	output logic            edgePulse
);
	import pic_pkg::*;
	logic [2:0] sync_r;
	logic       rise;
	logic       fall;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_r <= 3'h0;
		end else begin
			sync_r <= {sync_r[1:0], pinIn};
		end
	end

	// compare stages 2 and 3 only; stage 1 may be metastable
	assign rise = sync_r[1] & ~sync_r[2];
	assign fall = ~sync_r[1] & sync_r[2];

	always_comb begin
		unique case (edgeSel)
			EDGE_OFF:  edgePulse = 1'b0;    // see [R14]
			EDGE_RISE: edgePulse = rise;    // see [R14]
			EDGE_FALL: edgePulse = fall;    // see [R14]
			EDGE_BOTH: edgePulse = rise | fall; // see [R14]
		endcase
	end
endmodule
`default_nettype wire

// file: design/pic_flag_bit.sv
// one sticky request flag with software write
`timescale 1ns/1ps
`default_nettype none
module pic_flag_bit (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// controls
	input  wire logic setPulse,
	input  wire logic wrEn,
	input  wire logic wrVal,
	// state
	output logic      flag_r
);
	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= 1'b0;
		end else if (setPulse) begin
			flag_r <= 1'b1;
		end else if (wrEn) begin
			flag_r <= wrVal;
		end
	end
endmodule
`default_nettype wire

// file: design/pic_top.sv
// primary interrupt control: four control registers, edge select, status and mask
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pic_top (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// register port
	input  wire pic_pkg::pic_bus_t bus,
	output logic [7:0]             rdata,
	// request sources
	input  wire logic [3:0]        extPin,
	input  wire pic_pkg::pic_src_t src,
	// to processor
	output logic                   irqReq,
	output logic                   irqOut
);
	import pic_pkg::*;

	logic [7:0] ctrl0_r;
	logic [7:0] ctrl1_r;
	logic [7:0] ctrl2_r;
	logic [7:0] ctrl3_r;
	logic [7:0] edgeSel_r;
	logic [7:0] status_r;
	logic [7:0] mask_r;
	logic [7:0] rdata_nxt;
	logic [3:0] pinEdge;
	logic [3:0] pinFlag;
	logic [NUM_SRC-1:0] flagVec;
	logic [NUM_SRC-1:0] enVec;
	logic [NUM_SRC-1:0] pending;
	logic [7:0] evt;
	logic [3:0] firstIdx;
	logic wr0;
	logic wr3;

	function automatic logic hit(input logic [ADDR_W-1:0] off);
		return bus.addr == off;
	endfunction

	assign wr0 = bus.wr & hit(OFF_CTRL0);
	assign wr3 = bus.wr & hit(OFF_CTRL3);

	// pin edge detection and pin flags
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : gPin
			pic_edge_detect uEdge (
				.mclk      (mclk),
				.rst_n     (rst_n),
				.pinIn     (extPin[g]),
				.edgeSel   (edgeSel_r[2*g+1:2*g]),
				.edgePulse (pinEdge[g])
			);
		end
	endgenerate

	pic_flag_bit uPin0 (.mclk(mclk), .rst_n(rst_n), .setPulse(pinEdge[0]),
		.wrEn(wr0), .wrVal(bus.wdata[4]), .flag_r(pinFlag[0])); // see [R4]
	pic_flag_bit uPin1 (.mclk(mclk), .rst_n(rst_n), .setPulse(pinEdge[1]),
		.wrEn(wr0), .wrVal(bus.wdata[5]), .flag_r(pinFlag[1])); // see [R4]
	pic_flag_bit uPin2 (.mclk(mclk), .rst_n(rst_n), .setPulse(pinEdge[2]),
		.wrEn(wr3), .wrVal(bus.wdata[4]), .flag_r(pinFlag[2])); // see [R13]
	pic_flag_bit uPin3 (.mclk(mclk), .rst_n(rst_n), .setPulse(pinEdge[3]),
		.wrEn(wr3), .wrVal(bus.wdata[5]), .flag_r(pinFlag[3])); // see [R13]

	// register 0: bit 7 unimplemented, bits 6 and 3 plain storage left to software
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_r <= CTRL0_RST;
		end else if (wr0) begin
			ctrl0_r <= bus.wdata & CTRL0_IMPL & ~CTRL0_FLAGS; // see [R1] [R2] [R3] [R5]
		end
	end

	// registers 1 and 2: flags set by sources, set wins over write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_r <= CTRL_RST; // see [R16]
		end else begin
			if (bus.wr && hit(OFF_CTRL1)) begin
				ctrl1_r <= bus.wdata; // see [R16]
			end
			if (src.converter) begin
				ctrl1_r[7] <= 1'b1; // see [R6]
			end
			if (src.group[1]) begin
				ctrl1_r[6] <= 1'b1; // see [R8]
			end
			if (src.group[0]) begin
				ctrl1_r[5] <= 1'b1; // see [R8]
			end
			if (src.cmp1) begin
				ctrl1_r[4] <= 1'b1; // see [R7]
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl2_r <= CTRL_RST; // see [R16]
		end else begin
			if (bus.wr && hit(OFF_CTRL2)) begin
				ctrl2_r <= bus.wdata;
			end
			if (src.group[3]) begin
				ctrl2_r[7] <= 1'b1; // see [R11]
			end
			if (src.tick[1]) begin
				ctrl2_r[6] <= 1'b1; // see [R10]
			end
			if (src.tick[0]) begin
				ctrl2_r[5] <= 1'b1; // see [R10]
			end
			if (src.group[2]) begin
				ctrl2_r[4] <= 1'b1; // see [R11]
			end
		end
	end

	// register 3: pin flags live in the flag cells
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl3_r <= CTRL_RST; // see [R16]
		end else begin
			if (wr3) begin
				ctrl3_r <= bus.wdata & ~CTRLN_FLAGS | bus.wdata & 8'hc0;
			end
			if (src.group[5]) begin
				ctrl3_r[7] <= 1'b1; // see [R12]
			end
			if (src.group[4]) begin
				ctrl3_r[6] <= 1'b1; // see [R12]
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			edgeSel_r <= 8'h00;
		end else if (bus.wr && hit(OFF_EDGESEL)) begin
			edgeSel_r <= bus.wdata; // see [R14]
		end
	end

	// flag and enable vectors, same order
	assign flagVec = {pinFlag[3], pinFlag[2], ctrl3_r[7], ctrl3_r[6],
		ctrl2_r[7], ctrl2_r[4], ctrl2_r[6], ctrl2_r[5],
		ctrl1_r[7], ctrl1_r[4], ctrl1_r[6], ctrl1_r[5],
		pinFlag[1], pinFlag[0]};
	assign enVec = {ctrl3_r[1], ctrl3_r[0], ctrl3_r[3], ctrl3_r[2],
		ctrl2_r[3], ctrl2_r[0], ctrl2_r[2], ctrl2_r[1],
		ctrl1_r[3], ctrl1_r[0], ctrl1_r[2], ctrl1_r[1],
		ctrl0_r[2], ctrl0_r[1]}; // see [R5] [R9] [R10] [R11] [R12] [R13]
	assign pending = flagVec & enVec & {NUM_SRC{ctrl0_r[BIT_MASTER]}}; // see [R3] [R15]
	assign irqReq = |pending; // see [R15]

	// lowest pending index for the vector register
	always_comb begin
		firstIdx = 4'hf;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i]) begin
				firstIdx = 4'(i);
			end
		end
	end

	// status: sticky per-class events, cleared by reading it
	assign evt = {2'h0, |pinEdge, src.converter, src.cmp1, |src.group, |src.tick, |pending};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= 8'h00;
		end else if (bus.rd && hit(OFF_STATUS)) begin
			status_r <= evt; // new events in the read cycle are kept
		end else begin
			status_r <= status_r | evt;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= 8'h00;
		end else if (bus.wr && hit(OFF_MASK)) begin
			mask_r <= bus.wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= |(status_r & mask_r);
		end
	end

	// read mux, data in the cycle after the strobe
	always_comb begin
		unique case (bus.addr)
			OFF_CTRL0:   rdata_nxt = (ctrl0_r & CTRL0_IMPL) | {2'h0, pinFlag[1], pinFlag[0], 4'h0}; // see [R1]
			OFF_CTRL1:   rdata_nxt = ctrl1_r;
			OFF_CTRL2:   rdata_nxt = ctrl2_r;
			OFF_CTRL3:   rdata_nxt = {ctrl3_r[7:6], pinFlag[3], pinFlag[2], ctrl3_r[3:0]};
			OFF_EDGESEL: rdata_nxt = edgeSel_r;
			OFF_STATUS:  rdata_nxt = status_r;
			OFF_MASK:    rdata_nxt = mask_r;
			OFF_VECTOR:  rdata_nxt = {irqReq, 3'h0, firstIdx};
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			rdata <= rdata_nxt;
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// file: dv/pic_src_model.sv
// request source model: peripheral pulses and pin levels
`timescale 1ns/1ps
`default_nettype none
module pic_src_model (
	// commands from the bench
	input  wire logic              fire,
	input  wire logic [3:0]        sel,
	input  wire logic [3:0]        pinLvl,
	// towards the block
	output wire pic_pkg::pic_src_t src,
	output wire logic [3:0]        extPin
);
	import pic_pkg::*;
	// one source per pulse keeps each flag check unambiguous
	assign src = fire ? pic_src_t'(10'h001 << sel) : pic_src_t'(10'h000);
	assign extPin = pinLvl;
endmodule
`default_nettype wire

// file: dv/pic_checker.sv
// port assertions for the primary interrupt control block
`timescale 1ns/1ps
`default_nettype none
module pic_checker (
	// clock and reset
	input wire logic              mclk,
	input wire logic              rst_n,
	// register port
	input wire pic_pkg::pic_bus_t bus,
	input wire logic [7:0]        rdata,
	// sources and outputs
	input wire logic [3:0]        extPin,
	input wire pic_pkg::pic_src_t src,
	input wire logic              irqReq,
	input wire logic              irqOut
);
	import pic_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// a pulse followed at once by a read must show its flag
	property p_set(ev, a, b);
		ev ##1 (bus.rd && bus.addr == a) |=> rdata[b];
	endproperty
	a_rdata_idle_zero: assert property (!bus.rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_ctrl0_top_zero: assert property (bus.rd && bus.addr == OFF_CTRL0 |=> !rdata[7])
		else $error("control0 top bit not zero");
	a_master_off_gate: assert property (bus.wr && bus.addr == OFF_CTRL0 && !bus.wdata[0] |=> !irqReq)
		else $error("request with master enable off");
	a_conv_flag_set: assert property (p_set(src.converter, OFF_CTRL1, 7))
		else $error("converter flag not set");
	a_cmp_flag_set: assert property (p_set(src.cmp1, OFF_CTRL1, 4))
		else $error("comparator flag not set");
	a_grp1_flag_set: assert property (p_set(src.group[1], OFF_CTRL1, 6))
		else $error("group 1 flag not set");
	a_tick1_flag_set: assert property (p_set(src.tick[1], OFF_CTRL2, 6))
		else $error("tick 1 flag not set");
	a_grp3_flag_set: assert property (p_set(src.group[3], OFF_CTRL2, 7))
		else $error("group 3 flag not set");
	a_grp5_flag_set: assert property (p_set(src.group[5], OFF_CTRL3, 7))
		else $error("group 5 flag not set");
	c_irq_req: cover property (irqReq);
	c_irq_out: cover property (irqOut);
	c_status_read: cover property (bus.rd && bus.addr == OFF_STATUS);
endmodule
bind pic_top pic_checker i_pic_checker (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .extPin(extPin),
	.src(src), .irqReq(irqReq), .irqOut(irqOut));
`default_nettype wire

// file: dv/pic_tb_top.sv
// self-checking bench for the primary interrupt control block
`timescale 1ns/1ps
`default_nettype none
module pic_tb_top;
	import pic_pkg::*;
	logic       mclk, rst_n, fire, irqReq, irqOut;
	logic [3:0] sel, pinLvl, extPin;
	logic [7:0] rdata, d;
	pic_bus_t   bus;
	pic_src_t   src;
	int         n_errors, total_checks;
	// source index to register and flag bit; enable sits four bits lower
	int         regOf [10] = '{2, 2, 1, 1, 2, 2, 3, 3, 1, 1};
	int         bitOf [10] = '{5, 6, 5, 6, 4, 7, 6, 7, 4, 7};
	pic_top i_pic_top (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .extPin(extPin), .src(src),
		.irqReq(irqReq), .irqOut(irqOut));
	pic_src_model i_pic_src_model (.fire(fire), .sel(sel), .pinLvl(pinLvl), .src(src), .extPin(extPin));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		#1;
	endtask
	// also ends any source pulse, so a read can follow a pulse directly
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge mclk);
		fire <= 1'b0;
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic pulse_read(input int i, output logic [7:0] v);
		@(posedge mclk);
		fire <= 1'b1;
		sel <= 4'(i);
		rd(3'(regOf[i]), v);
	endtask
	task automatic t_reset();
		for (int a = 0; a < 4; a++) begin
			rd(3'(a), d);
			chk("control after reset", CTRL_RST, d);
		end
	endtask
	task automatic t_rw();
		wr(OFF_CTRL0, 8'hb7);
		rd(OFF_CTRL0, d);
		chk("control0 readback", 8'h37, d);
		chk("request with all set", 8'h01, {7'h0, irqReq});
		wr(OFF_CTRL0, 8'h36);
		chk("request with master off", 8'h00, {7'h0, irqReq});
		for (int a = 1; a < 4; a++) begin
			wr(3'(a), 8'hff);
			rd(3'(a), d);
			chk("control readback", 8'hff, d);
			wr(3'(a), 8'h00);
		end
		wr(OFF_CTRL0, 8'h01);
	endtask
	task automatic t_sources();
		logic [7:0] en;
		for (int i = 0; i < 10; i++) begin
			en = 8'h01 << (bitOf[i] - 4);
			wr(3'(regOf[i]), en);
			chk("request before pulse", 8'h00, {7'h0, irqReq});
			pulse_read(i, d);
			chk("flag after pulse", en | (8'h01 << bitOf[i]), d);
			chk("request after pulse", 8'h01, {7'h0, irqReq});
			wr(3'(regOf[i]), 8'h00);
			chk("request after clear", 8'h00, {7'h0, irqReq});
		end
	endtask
	// pin modes 0 rising, 1 falling, 2 both, 3 off
	task automatic t_pins();
		wr(OFF_EDGESEL, 8'h39);
		@(posedge mclk) pinLvl <= 4'hf;
		repeat (6) @(posedge mclk);
		rd(OFF_CTRL0, d);
		chk("pin flags on rise", 8'h11, d);
		rd(OFF_CTRL3, d);
		chk("pin2 flag on rise", 8'h10, d);
		wr(OFF_CTRL0, 8'h01);
		wr(OFF_CTRL3, 8'h00);
		@(posedge mclk) pinLvl <= 4'h0;
		repeat (6) @(posedge mclk);
		rd(OFF_CTRL0, d);
		chk("pin flags on fall", 8'h21, d);
		rd(OFF_CTRL3, d);
		chk("pin2 flag on fall", 8'h10, d);
		wr(OFF_CTRL3, 8'h00);
	endtask
	task automatic t_irq();
		rd(OFF_STATUS, d);
		wr(OFF_MASK, 8'h10);
		pulse_read(9, d);
		repeat (2) @(posedge mclk);
		#1 chk("line while converter pending", 8'h01, {7'h0, irqOut});
		rd(OFF_STATUS, d);
		chk("status converter bit", 8'h10, d & 8'h10);
		repeat (2) @(posedge mclk);
		#1 chk("line after status read", 8'h00, {7'h0, irqOut});
		wr(OFF_MASK, 8'h00);
		pulse_read(8, d);
		repeat (2) @(posedge mclk);
		#1 chk("line while masked", 8'h00, {7'h0, irqOut});
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		bus = '0;
		fire = 1'b0;
		sel = 4'h0;
		pinLvl = 4'h0;
		rst_n = 1'b0;
		n_errors = 0;
		total_checks = 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_rw();
		t_sources();
		t_pins();
		t_irq();
		summarize();
	end
	// hang guard, far above the length of the sequence
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
